// >>> rtl/idt_flash_dev.sv
// What this block does
// - Unique ID: opcode, four dummies, 128 bits
// - Unique ID is fixed, never host-writable
// - Four-byte mode: five dummy bytes instead
// - Table read: opcode, three address, one dummy
// - Chip select high stops output at once
// - Bytes 00H-03H hold the signature
// - Revisions 00H, 01H and header count 01H
// - Unused header bytes always read FFH
// - First header: standard table at 30H
// - Second header: vendor table at 60H
// - Byte 30H reads E5H
// - Byte 30H bits 3 and 4 zero
// - Byte 32H reads FBH
// - Bytes 38H-39H describe 1-4-4 read
// - Bytes 3AH-3BH describe 1-1-4 read
`timescale 1ns/1ps
module idt_flash_dev #(
  // Factory number, arbitrary default; one per part
  parameter logic [127:0] UNIQUE_ID = idt_pkg::UID_DEFAULT,
  // Arbitrary value, stands in for the vendor identification code
  parameter logic [7:0] VENDOR_CODE = idt_pkg::VENDOR_CODE_DEFAULT
) (
  // Serial link
  idt_link_if.dev link,
  // Device configuration
  input wire logic four_byte_mode
);

  // ==========================================
  // Types
  typedef enum logic [2:0] {
    PH_CMD,
    PH_ADDR,
    PH_DUMMY,
    PH_DATA,
    PH_SKIP
  } idt_phase_e;

  typedef struct packed {
    idt_phase_e phase;
    logic [7:0] in_sh;
    logic [5:0] cnt;
    logic [5:0] dummy_bits;
    logic is_uid;
    logic [23:0] addr;
    logic [7:0] out_sh;
    logic driving;
    logic fourb_meta;
    logic fourb_sync;
  } idt_dev_s;

  localparam idt_dev_s DEV_RST = '{
    phase: PH_CMD,
    in_sh: 8'h00,
    cnt: 6'h00,
    dummy_bits: 6'h00,
    is_uid: 1'b0,
    addr: 24'h00_0000,
    out_sh: 8'h00,
    driving: 1'b0,
    fourb_meta: 1'b0,
    fourb_sync: 1'b0
  };

  // ==========================================
  // Helpers
  // The identifier is a parameter, so no link sequence can alter it
  function automatic logic [7:0] uid_byte(input logic [3:0] idx);
    logic [6:0] base;
    base = 7'd127 - {idx, 3'b000};
    uid_byte = UNIQUE_ID[base -: 8];
  endfunction : uid_byte

  idt_dev_s dev_r;
  idt_dev_s dev_nxt;
  logic [23:0] rom_addr;
  logic [7:0] rom_data;
  logic [7:0] next_byte;
  logic [7:0] cmd_byte;

  // Look one byte ahead while streaming so the reload is ready at the byte edge
  assign rom_addr = (dev_r.phase == PH_DATA) ? dev_r.addr + 24'h00_0001 : dev_r.addr;

  idt_param_rom #(
    .VENDOR_CODE(VENDOR_CODE)
  ) u_rom (
    .addr(rom_addr),
    .data(rom_data)
  );

  assign next_byte = dev_r.is_uid ? uid_byte(rom_addr[3:0]) : rom_data;
  assign cmd_byte = {dev_r.in_sh[6:0], link.mosi};

  // ==========================================
  // Frame sequencer, one step per rising serial clock
  always_comb begin
    dev_nxt = dev_r;
    dev_nxt.fourb_meta = four_byte_mode;
    dev_nxt.fourb_sync = dev_r.fourb_meta;
    case (dev_r.phase)
      PH_CMD: begin
        dev_nxt.in_sh = cmd_byte;
        dev_nxt.cnt = dev_r.cnt + 6'd1;
        if (dev_r.cnt == 6'd7) begin
          dev_nxt.cnt = 6'd0;
          if (cmd_byte == idt_pkg::OP_UNIQUE_ID_READ) begin
            dev_nxt.is_uid = 1'b1;
            dev_nxt.addr = 24'h00_0000;
            dev_nxt.phase = PH_DUMMY;
            if (dev_r.fourb_sync) begin
              dev_nxt.dummy_bits = 6'(idt_pkg::UID_DUMMY_BITS_4B);
            end else begin
              dev_nxt.dummy_bits = 6'(idt_pkg::UID_DUMMY_BITS_3B);
            end
          end else if (cmd_byte == idt_pkg::OP_PARAM_TABLE_READ) begin
            dev_nxt.is_uid = 1'b0;
            dev_nxt.phase = PH_ADDR;
          end else begin
            // Other opcodes belong to other blocks; stay quiet until deselect
            dev_nxt.phase = PH_SKIP;
          end
        end
      end
      PH_ADDR: begin
        dev_nxt.addr = {dev_r.addr[22:0], link.mosi};
        dev_nxt.cnt = dev_r.cnt + 6'd1;
        if (dev_r.cnt == 6'(idt_pkg::TABLE_ADDR_BITS - 1)) begin
          dev_nxt.cnt = 6'd0;
          dev_nxt.dummy_bits = 6'(idt_pkg::TABLE_DUMMY_BITS);
          dev_nxt.phase = PH_DUMMY;
        end
      end
      PH_DUMMY: begin
        dev_nxt.cnt = dev_r.cnt + 6'd1;
        if (dev_r.cnt == dev_r.dummy_bits - 6'd1) begin
          dev_nxt.cnt = 6'd0;
          dev_nxt.out_sh = next_byte;
          dev_nxt.driving = 1'b1;
          dev_nxt.phase = PH_DATA;
        end
      end
      PH_DATA: begin
        dev_nxt.cnt = {3'b000, dev_r.cnt[2:0] + 3'd1};
        if (dev_r.cnt[2:0] == 3'd7) begin
          dev_nxt.addr = rom_addr;
          dev_nxt.out_sh = next_byte;
        end else begin
          dev_nxt.out_sh = {dev_r.out_sh[6:0], 1'b0};
        end
      end
      PH_SKIP: begin
        dev_nxt.driving = 1'b0;
      end
      default: begin
        dev_nxt = DEV_RST;
      end
    endcase
  end

  // Deselect clears the frame at once: the serial clock may stop afterwards
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      dev_r <= DEV_RST;
    end else begin
      dev_r <= dev_nxt;
    end
  end

  // ==========================================
  // Output pin
  assign link.miso_o = dev_r.out_sh[7];
  assign link.miso_oe = dev_r.driving & ~link.cs_n;

endmodule : idt_flash_dev

// >>> rtl/idt_link_if.sv
`timescale 1ns/1ps
interface idt_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;

  // Pulled high while nobody drives the line
  assign miso = miso_oe ? miso_o : 1'b1;

  modport dev (
    input cs_n,
    input sclk,
    input mosi,
    output miso_o,
    output miso_oe
  );

  modport host (
    output cs_n,
    output sclk,
    output mosi,
    input miso
  );
endinterface : idt_link_if

// >>> rtl/idt_param_rom.sv
`timescale 1ns/1ps
module idt_param_rom #(
  // Arbitrary value, stands in for the vendor identification code
  parameter logic [7:0] VENDOR_CODE = idt_pkg::VENDOR_CODE_DEFAULT
) (
  // Lookup
  input wire logic [23:0] addr,
  output logic [7:0] data
);

  // ==========================================
  // Fixed table contents
  always_comb begin
    data = idt_pkg::UNUSED_BYTE;
    if (addr[23:8] == 16'h0000) begin
      case (addr[7:0])
        8'h00: data = 8'h53;
        8'h01: data = 8'h46;
        8'h02: data = 8'h44;
        8'h03: data = 8'h50;
        8'h04: data = 8'h00;
        8'h05: data = 8'h01;
        8'h06: data = 8'h01;
        8'h07: data = idt_pkg::UNUSED_BYTE;
        8'h08: data = 8'h00;
        8'h09: data = 8'h00;
        8'h0a: data = 8'h01;
        8'h0b: data = 8'h09;
        8'h0c: data = 8'h30;
        8'h0d: data = 8'h00;
        8'h0e: data = 8'h00;
        8'h0f: data = idt_pkg::UNUSED_BYTE;
        8'h10: data = VENDOR_CODE;
        8'h11: data = 8'h00;
        8'h12: data = 8'h01;
        8'h13: data = 8'h03;
        8'h14: data = 8'h60;
        8'h15: data = 8'h00;
        8'h16: data = 8'h00;
        8'h17: data = idt_pkg::UNUSED_BYTE;
        8'h30: data = 8'he5;
        8'h31: data = 8'h20;
        8'h32: data = 8'hfb;
        8'h34: data = 8'hff;
        8'h35: data = 8'hff;
        8'h36: data = 8'hff;
        8'h37: data = 8'h1f;
        8'h38: data = 8'h44;
        8'h39: data = 8'heb;
        8'h3a: data = 8'h08;
        8'h3b: data = 8'h6b;
        default: data = idt_pkg::UNUSED_BYTE;
      endcase
    end
  end

endmodule : idt_param_rom

// >>> rtl/idt_pkg.sv
package idt_pkg;

  // ==========================================
  // Link opcodes and frame shape
  localparam logic [7:0] OP_UNIQUE_ID_READ = 8'h4b;
  localparam logic [7:0] OP_PARAM_TABLE_READ = 8'h5a;
  localparam int UID_DUMMY_BITS_3B = 32;
  localparam int UID_DUMMY_BITS_4B = 40;
  localparam int TABLE_ADDR_BITS = 24;
  localparam int TABLE_DUMMY_BITS = 8;
  localparam int UID_BYTES = 16;
  localparam int UID_BITS = 128;

  // ==========================================
  // Device parameter defaults and fill value
  localparam logic [127:0] UID_DEFAULT = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
  localparam logic [7:0] VENDOR_CODE_DEFAULT = 8'h3c;
  localparam logic [7:0] UNUSED_BYTE = 8'hff;

  // ==========================================
  // Host register map (byte addresses) and fields
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_LEN = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_DATA0 = 8'h10;
  localparam logic [7:0] REG_DATA3 = 8'h1c;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_KIND_BIT = 1;
  localparam int CMD_FOURB_BIT = 2;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_DONE_BIT = 1;
  localparam logic [4:0] LEN_RESET = 5'h10;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ==========================================
  // Timing: serial clock half period in aclk cycles
  localparam int SCLK_HALF_CYCLES = 4;

endpackage : idt_pkg

// >>> rtl/idt_spi_host.sv
`timescale 1ns/1ps
module idt_spi_host #(
  parameter int SCLK_HALF = idt_pkg::SCLK_HALF_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Serial link
  idt_link_if.host link
);

  // ==========================================
  // Types
  typedef enum logic [1:0] {
    H_IDLE,
    H_LOW,
    H_HIGH,
    H_END
  } idt_hstate_e;

  typedef struct packed {
    idt_hstate_e st;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic [7:0] div;
    logic [8:0] bitno;
    logic [8:0] total;
    logic [5:0] txbits;
    logic [47:0] tx;
    logic [127:0] rx;
    logic miso_meta;
    logic miso_sync;
    logic kind;
    logic fourb;
    logic [23:0] addr;
    logic [4:0] len;
    logic busy;
    logic done;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } idt_host_s;

  localparam idt_host_s HOST_RST = '{
    st: H_IDLE, cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0, div: 8'h00, bitno: 9'h000, total: 9'h000,
    txbits: 6'h00, tx: 48'h0000_0000_0000, rx: '0, miso_meta: 1'b1, miso_sync: 1'b1,
    kind: 1'b0, fourb: 1'b0, addr: 24'h00_0000, len: idt_pkg::LEN_RESET, busy: 1'b0,
    done: 1'b0, bvalid: 1'b0, bresp: 2'b00, rvalid: 1'b0, rresp: 2'b00, rdata: 32'h0000_0000
  };

  idt_host_s h_r;
  idt_host_s h_nxt;
  logic wr_go;

  function automatic logic [31:0] reg_read(input idt_host_s s, input logic [7:0] a);
    logic [6:0] top;
    top = 7'd127 - {a[3:2], 5'b00000};
    reg_read = 32'h0000_0000;
    if (a == idt_pkg::REG_CMD) begin
      reg_read[idt_pkg::CMD_KIND_BIT] = s.kind;
      reg_read[idt_pkg::CMD_FOURB_BIT] = s.fourb;
    end else if (a == idt_pkg::REG_ADDR) begin
      reg_read[23:0] = s.addr;
    end else if (a == idt_pkg::REG_LEN) begin
      reg_read[4:0] = s.len;
    end else if (a == idt_pkg::REG_STATUS) begin
      reg_read[idt_pkg::STATUS_BUSY_BIT] = s.busy;
      reg_read[idt_pkg::STATUS_DONE_BIT] = s.done;
    end else if (a >= idt_pkg::REG_DATA0 && a <= idt_pkg::REG_DATA3) begin
      reg_read = s.rx[top -: 32];
    end
  endfunction : reg_read

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= idt_pkg::REG_DATA3);
  endfunction : mapped

  assign wr_go = awvalid & wvalid & ~h_r.bvalid;
  assign awready = wr_go;
  assign wready = wr_go;
  assign arready = ~h_r.rvalid;

  // ==========================================
  // Bus slave and serial engine
  always_comb begin
    logic [4:0] nbytes;
    logic [5:0] tb;
    nbytes = 5'd0;
    tb = 6'd0;
    h_nxt = h_r;
    h_nxt.miso_meta = link.miso;
    h_nxt.miso_sync = h_r.miso_meta;
    if (h_r.bvalid && bready) begin
      h_nxt.bvalid = 1'b0;
    end
    if (h_r.rvalid && rready) begin
      h_nxt.rvalid = 1'b0;
    end
    if (arvalid && !h_r.rvalid) begin
      h_nxt.rvalid = 1'b1;
      h_nxt.rdata = reg_read(h_r, araddr);
      h_nxt.rresp = mapped(araddr) ? idt_pkg::RESP_OKAY : idt_pkg::RESP_SLVERR;
    end
    case (h_r.st)
      H_IDLE: begin
        h_nxt.cs_n = 1'b1;
        h_nxt.sclk = 1'b0;
        if (wr_go && awaddr == idt_pkg::REG_CMD && wstrb[0]) begin
          h_nxt.kind = wdata[idt_pkg::CMD_KIND_BIT];
          h_nxt.fourb = wdata[idt_pkg::CMD_FOURB_BIT];
          if (wdata[idt_pkg::CMD_START_BIT]) begin
            nbytes = (h_r.len == 5'd0 || h_r.len > 5'(idt_pkg::UID_BYTES)) ? 5'(idt_pkg::UID_BYTES) : h_r.len;
            if (wdata[idt_pkg::CMD_KIND_BIT]) begin
              h_nxt.tx = {idt_pkg::OP_PARAM_TABLE_READ, h_r.addr, 16'h0000};
              tb = 6'(8 + idt_pkg::TABLE_ADDR_BITS + idt_pkg::TABLE_DUMMY_BITS);
            end else if (wdata[idt_pkg::CMD_FOURB_BIT]) begin
              h_nxt.tx = {idt_pkg::OP_UNIQUE_ID_READ, 40'h00_0000_0000};
              tb = 6'(8 + idt_pkg::UID_DUMMY_BITS_4B);
            end else begin
              h_nxt.tx = {idt_pkg::OP_UNIQUE_ID_READ, 40'h00_0000_0000};
              tb = 6'(8 + idt_pkg::UID_DUMMY_BITS_3B);
            end
            h_nxt.txbits = tb;
            h_nxt.total = 9'(tb) + {1'b0, nbytes, 3'b000};
            h_nxt.mosi = h_nxt.tx[47];
            h_nxt.cs_n = 1'b0;
            h_nxt.bitno = 9'h000;
            h_nxt.div = 8'h00;
            h_nxt.rx = '0;
            h_nxt.busy = 1'b1;
            h_nxt.done = 1'b0;
            h_nxt.st = H_LOW;
          end
        end
      end
      H_LOW: begin
        h_nxt.div = h_r.div + 8'd1;
        if (h_r.div == 8'(SCLK_HALF - 1)) begin
          h_nxt.div = 8'h00;
          h_nxt.sclk = 1'b1;
          h_nxt.st = H_HIGH;
          if (h_r.bitno >= 9'(h_r.txbits)) begin
            h_nxt.rx[7'd127 - 7'(h_r.bitno - 9'(h_r.txbits))] = h_r.miso_sync;
          end
        end
      end
      H_HIGH: begin
        h_nxt.div = h_r.div + 8'd1;
        if (h_r.div == 8'(SCLK_HALF - 1)) begin
          h_nxt.div = 8'h00;
          h_nxt.sclk = 1'b0;
          h_nxt.bitno = h_r.bitno + 9'd1;
          h_nxt.tx = {h_r.tx[46:0], 1'b0};
          h_nxt.mosi = h_r.tx[46];
          h_nxt.st = (h_r.bitno + 9'd1 == h_r.total) ? H_END : H_LOW;
        end
      end
      H_END: begin
        h_nxt.div = h_r.div + 8'd1;
        if (h_r.div == 8'(SCLK_HALF - 1)) begin
          h_nxt.cs_n = 1'b1;
          h_nxt.busy = 1'b0;
          h_nxt.done = 1'b1;
          h_nxt.st = H_IDLE;
        end
      end
      default: begin
        h_nxt.st = H_IDLE;
      end
    endcase
    if (wr_go) begin
      h_nxt.bvalid = 1'b1;
      h_nxt.bresp = mapped(awaddr) ? idt_pkg::RESP_OKAY : idt_pkg::RESP_SLVERR;
      if (awaddr == idt_pkg::REG_ADDR) begin
        for (int i = 0; i < 3; i++) begin
          if (wstrb[i]) begin
            h_nxt.addr[8*i +: 8] = wdata[8*i +: 8];
          end
        end
      end else if (awaddr == idt_pkg::REG_LEN && wstrb[0]) begin
        h_nxt.len = wdata[4:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      h_r <= HOST_RST;
    end else begin
      h_r <= h_nxt;
    end
  end

  // ==========================================
  // Outputs
  assign bvalid = h_r.bvalid;
  assign bresp = h_r.bresp;
  assign rvalid = h_r.rvalid;
  assign rresp = h_r.rresp;
  assign rdata = h_r.rdata;
  assign link.cs_n = h_r.cs_n;
  assign link.sclk = h_r.sclk;
  assign link.mosi = h_r.mosi;

endmodule : idt_spi_host

// >>> testbench/id_and_param_table_reader_bench.sv
`timescale 1ns/1ps
module id_and_param_table_reader_bench;
  // Arbitrary values for the factory number and the vendor code
  localparam logic [127:0] BENCH_UID = 128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0;
  localparam logic [7:0] BENCH_VENDOR = 8'h5e;
  localparam int TIME_LIMIT = 40000;

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic four_byte_mode = 1'b0;
  logic [31:0] head_sh = 32'h0000_0000;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int frame_bits = 0;
  logic [1:0] last_rresp = 2'b00;

  idt_link_if link();
  idt_spi_host i_idt_spi_host (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .link(link));
  idt_flash_dev #(.UNIQUE_ID(BENCH_UID), .VENDOR_CODE(BENCH_VENDOR)) i_idt_flash_dev (.link(link),
    .four_byte_mode(four_byte_mode));
  idt_link_props i_idt_link_props (.aclk(aclk), .aresetn(aresetn), .cs_n(link.cs_n), .sclk(link.sclk),
    .mosi(link.mosi), .miso_o(link.miso_o), .miso_oe(link.miso_oe), .miso(link.miso));

  always #50 aclk = ~aclk;

  // ==========================================
  // Wire watcher: bits per frame and the frame head
  always @(negedge link.cs_n) frame_bits = 0;
  always @(posedge link.sclk) begin
    if (!link.cs_n) begin
      if (frame_bits < 32) head_sh = {head_sh[30:0], link.mosi};
      frame_bits++;
    end
  end

  always @(posedge aclk) begin
    cycles++;
    if (cycles == TIME_LIMIT) begin
      fail_count++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      conclude();
    end
  end

  // ==========================================
  // Shared tasks
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check32

  task automatic check_count(input int got, input int exp, input string what);
    checks_done++;
    if (got != exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask : check_count

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_done;
    bit w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awready === 1'b1) begin aw_done = 1; awvalid <= 1'b0; end
      if (wready === 1'b1) begin w_done = 1; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    last_rresp = rresp;
    rready <= 1'b0;
  endtask : axi_read

  task automatic run_op(input logic kind, input logic fourb, input logic [23:0] addr, input logic [4:0] len,
                        input int exp_bits);
    logic [1:0] r;
    logic [31:0] s;
    logic [7:0] op;
    op = kind ? idt_pkg::OP_PARAM_TABLE_READ : idt_pkg::OP_UNIQUE_ID_READ;
    four_byte_mode <= fourb;
    axi_write(idt_pkg::REG_LEN, {27'h0, len}, r);
    axi_write(idt_pkg::REG_ADDR, {8'h00, addr}, r);
    axi_write(idt_pkg::REG_CMD, {29'h0, fourb, kind, 1'b1}, r);
    check32({30'h0, r}, {30'h0, idt_pkg::RESP_OKAY}, "command write response");
    // A frame lasts far longer than one status read, so the first read sees busy
    axi_read(idt_pkg::REG_STATUS, s);
    check32(s, 32'h0000_0001, "status while busy");
    while (s[idt_pkg::STATUS_DONE_BIT] !== 1'b1) axi_read(idt_pkg::REG_STATUS, s);
    check32(s, 32'h0000_0002, "status when done");
    check_count(frame_bits, exp_bits, "frame bits");
    check32({24'h0, head_sh[31:24]}, {24'h0, op}, "opcode");
    if (kind) check32({8'h00, head_sh[23:0]}, {8'h00, addr}, "table address");
    axi_read(idt_pkg::REG_ADDR, s);
    check32(s, {8'h00, addr}, "address readback");
    axi_read(idt_pkg::REG_CMD, s);
    check32(s, {29'h0, fourb, kind, 1'b0}, "command readback");
  endtask : run_op

  task automatic check_data(input logic [127:0] exp);
    logic [31:0] d;
    for (int k = 0; k < 4; k++) begin
      axi_read(idt_pkg::REG_DATA0 + 8'(4 * k), d);
      check32(d, exp[127 - 32 * k -: 32], "received word");
    end
  endtask : check_data

  // ==========================================
  // Scenarios
  task automatic test_uid_plain();
    run_op(1'b0, 1'b0, 24'h00_0000, 5'h10, 168);
    check_data(BENCH_UID);
    $display("test_uid_plain done");
  endtask : test_uid_plain

  task automatic test_uid_four_byte();
    logic [1:0] r;
    // The data words are read-only, and the factory number must survive the attempt
    axi_write(idt_pkg::REG_DATA0, 32'hdead_beef, r);
    run_op(1'b0, 1'b1, 24'h00_0000, 5'h10, 176);
    check_data(BENCH_UID);
    four_byte_mode <= 1'b0;
    $display("test_uid_four_byte done");
  endtask : test_uid_four_byte

  task automatic test_table_head();
    run_op(1'b1, 1'b0, 24'h00_0000, 5'h10, 168);
    check_data(128'h5346_4450_0001_01ff_0000_0109_3000_00ff);
    $display("test_table_head done");
  endtask : test_table_head

  task automatic test_vendor_head();
    run_op(1'b1, 1'b0, 24'h00_0010, 5'h08, 104);
    check_data({BENCH_VENDOR, 56'h00_0103_6000_00ff, 64'h0000_0000_0000_0000});
    $display("test_vendor_head done");
  endtask : test_vendor_head

  task automatic test_capabilities();
    run_op(1'b1, 1'b0, 24'h00_0030, 5'h0c, 136);
    check_data(128'he520_fbff_ffff_ff1f_44eb_086b_0000_0000);
    $display("test_capabilities done");
  endtask : test_capabilities

  task automatic test_abort_wrap();
    // Three bytes across the top of the address space, then deselect mid-stream
    run_op(1'b1, 1'b0, 24'hff_ffff, 5'h03, 64);
    check_data(128'hff53_4600_0000_0000_0000_0000_0000_0000);
    $display("test_abort_wrap done");
  endtask : test_abort_wrap

  task automatic test_bad_address();
    logic [1:0] r;
    logic [31:0] d;
    axi_write(8'h20, 32'h0000_0001, r);
    check32({30'h0, r}, {30'h0, idt_pkg::RESP_SLVERR}, "unmapped write response");
    axi_write(8'h06, 32'h0000_0001, r);
    check32({30'h0, r}, {30'h0, idt_pkg::RESP_SLVERR}, "unaligned write response");
    axi_read(8'h20, d);
    check32({30'h0, last_rresp}, {30'h0, idt_pkg::RESP_SLVERR}, "unmapped read response");
    // Neither refused write may have touched the length left by the previous test
    axi_read(idt_pkg::REG_LEN, d);
    check32(d, 32'h0000_0003, "length readback");
    check32({30'h0, last_rresp}, {30'h0, idt_pkg::RESP_OKAY}, "mapped read response");
    $display("test_bad_address done");
  endtask : test_bad_address

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    test_uid_plain();
    test_uid_four_byte();
    test_table_head();
    test_vendor_head();
    test_capabilities();
    test_abort_wrap();
    test_bad_address();
    conclude();
  end
endmodule : id_and_param_table_reader_bench

// >>> testbench/idt_link_props.sv
`timescale 1ns/1ps
module idt_link_props (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Serial link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic miso
);
  // ==========================================
  // Helper: serial clock rises seen in this frame
  logic sclk_d_r;
  logic [8:0] rise_cnt_r;
  logic sclk_rise;
  assign sclk_rise = sclk & ~sclk_d_r;
  always_ff @(posedge aclk) begin
    sclk_d_r <= sclk;
    if (cs_n) begin
      rise_cnt_r <= 9'h000;
    end else if (sclk_rise) begin
      rise_cnt_r <= rise_cnt_r + 9'h001;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================
  // Assertions
  // Once the device takes the line it keeps it until deselect
  chk_drive_holds: assert property (!cs_n && $past(miso_oe) |-> miso_oe)
    else $error("miso released while still selected");
  chk_release_quiet: assert property ($rose(cs_n) |-> !miso_oe && miso)
    else $error("miso still driven after deselect");
  chk_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("serial clock moved outside a frame");
  chk_sclk_high_time: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("serial clock high phase wrong length");
  chk_mosi_steady: assert property (!cs_n && sclk |-> $stable(mosi))
    else $error("mosi changed while serial clock high");
  chk_miso_on_rise: assert property (!cs_n && !$past(cs_n) && $changed(miso_o) |-> $rose(sclk))
    else $error("miso changed away from a rising serial clock");
  // Opcode plus four dummies, or opcode plus address and dummy, are 40 bits either way; five dummies make 48
  chk_drive_after_head: assert property (miso_oe |-> (sclk_rise ? rise_cnt_r + 9'h001 : rise_cnt_r) >= 9'h028)
    else $error("miso driven before the frame head ended");
  chk_select_setup: assert property ($fell(cs_n) |-> !sclk [*4] ##1 sclk)
    else $error("first serial clock edge mistimed after select");

  // ==========================================
  // Covers
  cov_drive: cover property ($rose(miso_oe));
  cov_uid_frame: cover property ($rose(cs_n) && rise_cnt_r == 9'h0a8);
  cov_uid_long_frame: cover property ($rose(cs_n) && rise_cnt_r == 9'h0b0);
  cov_abort_frame: cover property ($rose(cs_n) && rise_cnt_r == 9'h040);
endmodule : idt_link_props
